//--- rtl/dcms_control_select.v
// Control method selection, voltage shaping and slip compensation
`timescale 1ns/1ps
`default_nettype none
`include "dcms_defs.vh"
// Function
// RULE1 - After reset the drive runs volts-per-hertz; flux vector is the only alternative.
// RULE2 - Volts-per-hertz mode keeps output voltage proportional to output frequency.
// RULE3 - Flux vector splits current into excitation and torque parts, boosts voltage.
// RULE4 - Capacity at sentinel forces volts-per-hertz whatever else is set.
// RULE5 - Motor type code picks standard, high-efficiency or constant-torque constants.
// RULE6 - Asserted switchover input overrides flux vector and gives volts-per-hertz.
// RULE7 - Switchover input needs function code 18 in a terminal function register.
// RULE8 - Method change requested while running waits until output stops.
// RULE9 - Change to volts-per-hertz while running applies only second functions at once.
// RULE10 - External controller should toggle switchover input only while stopped.
// RULE11 - Slip compensation enabled only for rated slip 0.01 to 50 percent.
// RULE12 - Rated slip zero or sentinel, the reset value, gives no slip compensation.
// RULE13 - Slip time constant 0.01 to 10 s, reset 0.5 s; smaller is faster.
// RULE14 - Constant-power select zero suppresses slip compensation above base frequency.
// RULE15 - Constant-power select at sentinel keeps slip compensation above base frequency.
// RULE16 - Slip parameters writable only while extended display select holds zero.
// RULE17 - Configuring party sets maximum frequency a little above commanded frequency.
// RULE18 - Effective method latched on entering stop, held while running; the code follows the request on every stopped cycle.
// RULE19 - Capacity accepts 0.1 to 15 kW for flux vector, sentinel means volts-per-hertz.
module dcms_control_select #(
    parameter NUM_TERM = 5,
    parameter TC_UNIT_CYCLES = `DCMS_TC_UNIT_NS / `DCMS_CLK_NS
) (
    input wire core_clk,
    input wire nrst,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire [NUM_TERM-1:0] termIn,
    input wire running,
    input wire [15:0] freqCmd,
    input wire signed [15:0] curAlpha,
    input wire signed [15:0] curBeta,
    input wire signed [15:0] fluxCos,
    input wire signed [15:0] fluxSin,
    output reg vfMode_q,
    output reg secondFunc_q,
    output reg slipActive_q,
    output reg tuningRequired_q,
    output reg [1:0] motorClass_q,
    output reg [15:0] outFreq_q,
    output reg [15:0] outVolt_q,
    output reg signed [15:0] exciteCur_q,
    output reg signed [15:0] torqueCur_q
);
    localparam integer PRESCALE = TC_UNIT_CYCLES / 16;
    localparam [31:0] PRESCALE_W = (PRESCALE < 1) ? 32'd1 : PRESCALE;

    reg [15:0] capQ, mtypeQ, slipQ, tcQ, cpselQ, extQ, baseQ, ratedVQ, tuneQ;
    reg [15:0] termFnQ [0:NUM_TERM-1];
    reg runQ;
    reg pendingQ;
    reg [31:0] preQ;
    reg [15:0] unitQ;
    reg [15:0] slipFiltQ;
    reg [31:0] readD;
    wire [NUM_TERM-1:0] swHit;
    wire swInput;
    wire vfReq;
    wire wrTake;
    wire slipWrOk;
    wire [15:0] wd;
    wire divDone;
    wire [31:0] divQuot;
    wire slipValid;
    wire [31:0] slipProd;
    wire [63:0] slipScaled;
    wire [15:0] slipTarget;
    wire [31:0] slipTorque;
    wire signed [32:0] idSum, iqSum;
    wire signed [16:0] boost;
    wire [16:0] freqSum;
    wire [16:0] voltSum;
    wire slipTick;

    assign wd = avs_writedata[15:0];
    // Write takes effect at the edge where waitrequest is low
    assign wrTake = avs_write && !avs_waitrequest && (avs_byteenable[1:0] == 2'h3);
    // RULE16 slip write gate
    assign slipWrOk = (extQ == 16'h0000);

    // RULE7 terminal function match
    genvar gi;
    generate
        for (gi = 0; gi < NUM_TERM; gi = gi + 1)
        begin : g_term
            assign swHit[gi] = termIn[gi] && (termFnQ[gi] == `DCMS_FN_VF_SWITCH);
        end
    endgenerate
    assign swInput = |swHit;

    // RULE4 RULE6 requested method
    assign vfReq = (capQ == `DCMS_SENTINEL) || swInput;

    // Bus answer one cycle after request
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end
        else
        begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
            if (avs_read && avs_waitrequest)
                avs_readdata <= readD;
        end
    end

    // Read mux, unmapped reads as zero
    integer ri;
    always @*
    begin
        readD = 32'h00000000;
        case (avs_address)
            `DCMS_OFS_CAPACITY: readD = {16'h0000, capQ};
            `DCMS_OFS_MOTOR_TYPE: readD = {16'h0000, mtypeQ};
            `DCMS_OFS_RATED_SLIP: readD = {16'h0000, slipQ};
            `DCMS_OFS_SLIP_TC: readD = {16'h0000, tcQ};
            `DCMS_OFS_CPWR_SEL: readD = {16'h0000, cpselQ};
            `DCMS_OFS_EXT_DISP: readD = {16'h0000, extQ};
            `DCMS_OFS_BASE_FREQ: readD = {16'h0000, baseQ};
            `DCMS_OFS_RATED_VOLT: readD = {16'h0000, ratedVQ};
            `DCMS_OFS_TUNING: readD = {16'h0000, tuneQ};
            `DCMS_OFS_STATUS: readD = {25'h0000000, motorClass_q, pendingQ, tuningRequired_q,
                                       slipActive_q, secondFunc_q, vfMode_q};
            default: readD = 32'h00000000;
        endcase
        for (ri = 0; ri < NUM_TERM; ri = ri + 1)
            if (avs_address == (`DCMS_OFS_TERM_FN0 + ri[5:0] * 8'h04))
                readD = {16'h0000, termFnQ[ri]};
    end

    // Register writes, with range checks on capacity, motor type and slip registers only
    integer wi;
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            capQ <= `DCMS_SENTINEL;
            mtypeQ <= `DCMS_MT_STD;
            slipQ <= `DCMS_SENTINEL;
            tcQ <= `DCMS_RST_TC;
            cpselQ <= `DCMS_SENTINEL;
            extQ <= 16'h0000;
            baseQ <= `DCMS_RST_BASE_FREQ;
            ratedVQ <= `DCMS_RST_RATED_VOLT;
            tuneQ <= 16'h0000;
            for (wi = 0; wi < NUM_TERM; wi = wi + 1)
                termFnQ[wi] <= 16'h0000;
        end
        else if (wrTake)
        begin
            case (avs_address)
                // RULE19 capacity range
                `DCMS_OFS_CAPACITY:
                    if (wd == `DCMS_SENTINEL || (wd >= `DCMS_CAP_MIN && wd <= `DCMS_CAP_MAX))
                        capQ <= wd;
                // RULE5 valid type codes
                `DCMS_OFS_MOTOR_TYPE:
                    if (wd == `DCMS_MT_STD || wd == `DCMS_MT_CT || wd == `DCMS_MT_STD_TUNE ||
                        wd == `DCMS_MT_CT_TUNE || wd == `DCMS_MT_STD_ALT || wd == `DCMS_MT_HE ||
                        wd == `DCMS_MT_HE_ALT || wd == `DCMS_MT_CT_HE ||
                        wd == `DCMS_MT_CT_HE_ALT)
                        mtypeQ <= wd;
                // RULE11 RULE12 RULE16 slip range
                `DCMS_OFS_RATED_SLIP:
                    if (slipWrOk && (wd == 16'h0000 || wd == `DCMS_SENTINEL ||
                        (wd >= `DCMS_SLIP_MIN && wd <= `DCMS_SLIP_MAX)))
                        slipQ <= wd;
                // RULE13 RULE16 time constant range
                `DCMS_OFS_SLIP_TC:
                    if (slipWrOk && wd >= `DCMS_TC_MIN && wd <= `DCMS_TC_MAX)
                        tcQ <= wd;
                // RULE14 RULE15 RULE16 select codes
                `DCMS_OFS_CPWR_SEL:
                    if (slipWrOk && (wd == 16'h0000 || wd == `DCMS_SENTINEL))
                        cpselQ <= wd;
                `DCMS_OFS_EXT_DISP: extQ <= wd;
                `DCMS_OFS_BASE_FREQ: baseQ <= wd;
                `DCMS_OFS_RATED_VOLT: ratedVQ <= wd;
                `DCMS_OFS_TUNING: tuneQ <= wd;
                default: ;
            endcase
            for (wi = 0; wi < NUM_TERM; wi = wi + 1)
                if (avs_address == (`DCMS_OFS_TERM_FN0 + wi[5:0] * 8'h04))
                    termFnQ[wi] <= wd;
        end
    end

    // RULE1 RULE8 RULE9 RULE18 method latch
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            runQ <= 1'b0;
            vfMode_q <= 1'b1;
            pendingQ <= 1'b0;
            secondFunc_q <= 1'b0;
        end
        else
        begin
            runQ <= running;
            if (!running)
            begin
                // Stopped: effective method follows request
                vfMode_q <= vfReq;
                pendingQ <= 1'b0;
                secondFunc_q <= 1'b0;
            end
            else
            begin
                pendingQ <= (vfReq != vfMode_q);
                // Only the second set goes live mid-run
                secondFunc_q <= vfReq && !vfMode_q;
            end
        end
    end

    // RULE5 motor class and tuning flag
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            motorClass_q <= `DCMS_CLS_STD;
            tuningRequired_q <= 1'b0;
        end
        else
        begin
            if (mtypeQ == `DCMS_MT_HE || mtypeQ == `DCMS_MT_HE_ALT)
                motorClass_q <= `DCMS_CLS_HE;
            else if (mtypeQ == `DCMS_MT_CT || mtypeQ == `DCMS_MT_CT_TUNE ||
                     mtypeQ == `DCMS_MT_CT_HE || mtypeQ == `DCMS_MT_CT_HE_ALT)
                motorClass_q <= `DCMS_CLS_CT;
            else
                motorClass_q <= `DCMS_CLS_STD;
            tuningRequired_q <= (mtypeQ == `DCMS_MT_STD_TUNE || mtypeQ == `DCMS_MT_CT_TUNE) &&
                                (tuneQ == 16'h0000);
        end
    end

    // RULE3 current split by rotation into flux frame
    assign idSum = curAlpha * fluxCos + curBeta * fluxSin;
    assign iqSum = curBeta * fluxCos - curAlpha * fluxSin;
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            exciteCur_q <= 16'sh0000;
            torqueCur_q <= 16'sh0000;
        end
        else
        begin
            exciteCur_q <= idSum[30:15];
            torqueCur_q <= iqSum[30:15];
        end
    end

    // RULE2 voltage proportional to frequency, recomputed continuously
    dcms_divider #(
        .NUM_W(32),
        .DEN_W(16)
    ) u_div (
        .core_clk(core_clk),
        .nrst(nrst),
        .start(1'b1),
        .numer({16'h0000, freqCmd} * {16'h0000, ratedVQ}),
        .denom(baseQ),
        .busy_q(),
        .done_q(divDone),
        .quot_q(divQuot)
    );

    // RULE3 torque current boost in flux vector mode
    assign boost = (vfMode_q || torqueCur_q[15]) ? 17'sh00000
                 : {1'b0, torqueCur_q} >>> `DCMS_BOOST_SHIFT;
    assign voltSum = ((|divQuot[31:16]) ? 17'h0ffff : {1'b0, divQuot[15:0]}) + boost[16:0];
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            outVolt_q <= 16'h0000;
        else if (divDone)
            outVolt_q <= voltSum[16] ? 16'hffff : voltSum[15:0];
    end

    // RULE11 RULE12 slip valid range
    assign slipValid = (slipQ >= `DCMS_SLIP_MIN) && (slipQ <= `DCMS_SLIP_MAX);
    // Slip target from rated slip, frequency and torque fraction
    assign slipProd = {16'h0000, freqCmd} * {16'h0000, slipQ};
    assign slipScaled = slipProd * `DCMS_SLIP_SCALE;
    assign slipTorque = slipScaled[38:23] * (torqueCur_q[15] ? 16'h0000 : torqueCur_q);
    assign slipTarget = slipTorque[30:15];

    // RULE13 filter tick every time constant sixteenth
    assign slipTick = (preQ == PRESCALE_W - 32'd1) && (unitQ >= tcQ - 16'h0001);
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            preQ <= 32'h00000000;
            unitQ <= 16'h0000;
            slipFiltQ <= 16'h0000;
        end
        else
        begin
            preQ <= (preQ == PRESCALE_W - 32'd1) ? 32'h00000000 : preQ + 32'd1;
            if (preQ == PRESCALE_W - 32'd1)
                unitQ <= slipTick ? 16'h0000 : unitQ + 16'h0001;
            if (!slipActive_q)
                slipFiltQ <= 16'h0000;
            else if (slipTick)
                slipFiltQ <= (slipTarget >= slipFiltQ)
                    ? slipFiltQ + ((slipTarget - slipFiltQ) >> `DCMS_FILT_SHIFT)
                    : slipFiltQ - ((slipFiltQ - slipTarget) >> `DCMS_FILT_SHIFT);
        end
    end

    // RULE14 RULE15 constant power gate on output frequency
    assign freqSum = {1'b0, freqCmd} + {1'b0, slipFiltQ};
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            slipActive_q <= 1'b0;
            outFreq_q <= 16'h0000;
        end
        else
        begin
            slipActive_q <= slipValid && !vfMode_q &&
                            (cpselQ == `DCMS_SENTINEL || freqCmd <= baseQ);
            outFreq_q <= freqSum[16] ? 16'hffff : freqSum[15:0];
        end
    end
endmodule // dcms_control_select
`default_nettype wire

//--- rtl/dcms_defs.vh
// Constants for the drive control method and slip compensation block
`ifndef DCMS_DEFS_VH
`define DCMS_DEFS_VH

// Register byte offsets
`define DCMS_OFS_CAPACITY 8'h00
`define DCMS_OFS_MOTOR_TYPE 8'h04
`define DCMS_OFS_RATED_SLIP 8'h08
`define DCMS_OFS_SLIP_TC 8'h0c
`define DCMS_OFS_CPWR_SEL 8'h10
`define DCMS_OFS_EXT_DISP 8'h14
`define DCMS_OFS_TERM_FN0 8'h18
`define DCMS_OFS_BASE_FREQ 8'h2c
`define DCMS_OFS_RATED_VOLT 8'h30
`define DCMS_OFS_TUNING 8'h34
`define DCMS_OFS_STATUS 8'h38

// Sentinel, function code and range limits
`define DCMS_SENTINEL 16'h270f
`define DCMS_FN_VF_SWITCH 16'h0012
`define DCMS_CAP_MIN 16'h000a
`define DCMS_CAP_MAX 16'h05dc
`define DCMS_SLIP_MIN 16'h0001
`define DCMS_SLIP_MAX 16'h1388
`define DCMS_TC_MIN 16'h0001
`define DCMS_TC_MAX 16'h03e8

// Motor type codes
`define DCMS_MT_STD 16'h0000
`define DCMS_MT_CT 16'h0001
`define DCMS_MT_STD_TUNE 16'h0003
`define DCMS_MT_CT_TUNE 16'h000d
`define DCMS_MT_STD_ALT 16'h0017
`define DCMS_MT_HE 16'h0028
`define DCMS_MT_HE_ALT 16'h002b
`define DCMS_MT_CT_HE 16'h0032
`define DCMS_MT_CT_HE_ALT 16'h0035

// Motor constant classes
`define DCMS_CLS_STD 2'h0
`define DCMS_CLS_HE 2'h1
`define DCMS_CLS_CT 2'h2

// Reset values
`define DCMS_RST_TC 16'h0032
`define DCMS_RST_BASE_FREQ 16'h1770
`define DCMS_RST_RATED_VOLT 16'h07d0

// Status bit positions
`define DCMS_ST_VF 0
`define DCMS_ST_SECOND 1
`define DCMS_ST_SLIP 2
`define DCMS_ST_TUNE 3
`define DCMS_ST_PENDING 4
`define DCMS_ST_CLS 5

// Arithmetic constants
`define DCMS_SLIP_SCALE 32'h00000347
`define DCMS_SLIP_SHIFT 23
`define DCMS_Q15_SHIFT 15
`define DCMS_BOOST_SHIFT 4
`define DCMS_FILT_SHIFT 4

// Timing: slip time constant unit in ns, clock period in ns
`define DCMS_TC_UNIT_NS 10000000
`define DCMS_CLK_NS 25

`endif

//--- rtl/dcms_divider.v
// Sequential unsigned divider for the volts-per-hertz voltage
`timescale 1ns/1ps
`default_nettype none
module dcms_divider #(
    parameter NUM_W = 32,
    parameter DEN_W = 16
) (
    input wire core_clk,
    input wire nrst,
    input wire start,
    input wire [NUM_W-1:0] numer,
    input wire [DEN_W-1:0] denom,
    output reg busy_q,
    output reg done_q,
    output reg [NUM_W-1:0] quot_q
);
    reg [NUM_W-1:0] numQ;
    reg [DEN_W:0] remQ;
    reg [DEN_W-1:0] denQ;
    reg [5:0] cntQ;
    wire [DEN_W:0] remShift;
    wire [DEN_W:0] remSub;

    // Shift in next numerator bit and trial subtract
    assign remShift = {remQ[DEN_W-1:0], numQ[NUM_W-1]};
    assign remSub = remShift - {1'b0, denQ};

    // Restoring division, one quotient bit per clock
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            quot_q <= {NUM_W{1'b0}};
            numQ <= {NUM_W{1'b0}};
            remQ <= {(DEN_W+1){1'b0}};
            denQ <= {DEN_W{1'b0}};
            cntQ <= 6'h00;
        end
        else
        begin
            done_q <= 1'b0;
            if (!busy_q && start)
            begin
                busy_q <= 1'b1;
                numQ <= numer;
                denQ <= denom;
                remQ <= {(DEN_W+1){1'b0}};
                cntQ <= NUM_W[5:0];
            end
            else if (busy_q)
            begin
                if (remShift >= {1'b0, denQ})
                begin
                    remQ <= remSub;
                    numQ <= {numQ[NUM_W-2:0], 1'b1};
                end
                else
                begin
                    remQ <= remShift;
                    numQ <= {numQ[NUM_W-2:0], 1'b0};
                end
                cntQ <= cntQ - 6'h01;
                if (cntQ == 6'h01)
                begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                    // Zero denominator gives all ones
                    quot_q <= (remShift >= {1'b0, denQ}) ? {numQ[NUM_W-2:0], 1'b1}
                                                         : {numQ[NUM_W-2:0], 1'b0};
                end
            end
        end
    end
endmodule // dcms_divider
`default_nettype wire

//--- tb/dcms_term_ctrl.sv
// Model of the external controller driving the terminal inputs
`timescale 1ns/1ps
`default_nettype none
module dcms_term_ctrl (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic swCmd,
    input wire logic runCmd,
    input wire logic lateOk,
    input wire logic [3:0] auxCmd,
    output logic [4:0] termIn,
    output logic running
);
    // Run state and terminals 4:1 follow the commands one clock later; terminal 0 only while stopped or with lateOk
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            termIn <= 5'h00;
            running <= 1'b0;
        end
        else
        begin
            running <= runCmd;
            termIn[4:1] <= auxCmd;
            if (!running || lateOk)
            begin
                termIn[0] <= swCmd;
            end
        end
    end
endmodule // dcms_term_ctrl
`default_nettype wire

//--- tb/dcms_control_select_assertions.sv
// Checker watching the control select ports
`timescale 1ns/1ps
`default_nettype none
module dcms_control_select_chk (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    input wire logic running,
    input wire logic [15:0] freqCmd,
    input wire logic signed [15:0] curAlpha,
    input wire logic signed [15:0] curBeta,
    input wire logic signed [15:0] fluxCos,
    input wire logic signed [15:0] fluxSin,
    input wire logic vfMode_q,
    input wire logic secondFunc_q,
    input wire logic slipActive_q,
    input wire logic [15:0] outFreq_q,
    input wire logic signed [15:0] exciteCur_q,
    input wire logic signed [15:0] torqueCur_q
);
    logic signed [31:0] exNext;
    logic signed [31:0] tqNext;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // Full-width current products
    assign exNext = curAlpha * fluxCos + curBeta * fluxSin;
    assign tqNext = curBeta * fluxCos - curAlpha * fluxSin;
    bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered next cycle");
    bus_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    upper_zero_a: assert property (!avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
        else $error("upper read data not zero");
    method_hold_a: assert property (running && $past(running) |-> vfMode_q == $past(vfMode_q))
        else $error("method changed while running");
    second_clear_a: assert property ($past(!running) |-> !secondFunc_q)
        else $error("second function set while stopped");
    second_fv_a: assert property (secondFunc_q |-> !vfMode_q && $past(running))
        else $error("second function outside pending switch");
    slip_fv_a: assert property ($past(vfMode_q) |-> !slipActive_q)
        else $error("slip compensation in volts per hertz");
    freq_pass_a: assert property ((!slipActive_q && $stable(freqCmd))[*3] |-> outFreq_q == freqCmd)
        else $error("output frequency not command without slip");
    current_split_a: assert property (nrst && $past(nrst) |->
        exciteCur_q == $past(exNext[30:15]) && torqueCur_q == $past(tqNext[30:15]))
        else $error("current split wrong");
    cover property (secondFunc_q);
    cover property (slipActive_q);
    cover property (!vfMode_q ##1 vfMode_q);
endmodule // dcms_control_select_chk
bind dcms_control_select dcms_control_select_chk u_chk (.core_clk(core_clk), .nrst(nrst),
    .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .avs_readdata(avs_readdata), .running(running), .freqCmd(freqCmd), .curAlpha(curAlpha),
    .curBeta(curBeta), .fluxCos(fluxCos), .fluxSin(fluxSin), .vfMode_q(vfMode_q),
    .secondFunc_q(secondFunc_q), .slipActive_q(slipActive_q), .outFreq_q(outFreq_q),
    .exciteCur_q(exciteCur_q), .torqueCur_q(torqueCur_q));
`default_nettype wire

//--- tb/drive_control_mode_select_tb.sv
// Testbench for the control select block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin errors++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module drive_control_mode_select_tb;
    logic core_clk = 1'b0, nrst = 1'b0, avsRead = 1'b0, avsWrite = 1'b0, avsWait;
    logic [7:0] avsAddr = 8'h00;
    logic [31:0] avsWdata = 32'h0, avsRdata;
    logic swCmd = 1'b0, runCmd = 1'b0, lateOk = 1'b0, vfMode, second, slip, tune, running;
    logic [3:0] auxCmd = 4'h0;
    logic [4:0] termIn;
    logic [15:0] freqCmd = 16'h0000, outFreq, outVolt;
    logic signed [15:0] curA = 0, curB = 0, fCos = 0, fSin = 0, exc, trq;
    logic [1:0] mclass;
    logic [7:0] rAddr [11] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h2c,
        8'h30, 8'h34, 8'h38};
    logic [15:0] rVal [11] = '{16'h270f, 0, 16'h270f, 16'h0032, 16'h270f, 0, 0, 16'h1770,
        16'h07d0, 0, 16'h0001};
    logic [15:0] mCode [9] = '{0, 1, 3, 13, 23, 40, 43, 50, 53};
    logic [1:0] mCls [9] = '{0, 2, 0, 2, 0, 1, 1, 2, 2};
    int errors = 0, compares = 0, cycles = 0;
    dcms_control_select #(.NUM_TERM(5), .TC_UNIT_CYCLES(32)) u_dut (.core_clk(core_clk),
        .nrst(nrst), .avs_address(avsAddr), .avs_read(avsRead), .avs_write(avsWrite),
        .avs_writedata(avsWdata), .avs_byteenable(4'hf), .avs_readdata(avsRdata),
        .avs_waitrequest(avsWait), .termIn(termIn), .running(running), .freqCmd(freqCmd),
        .curAlpha(curA), .curBeta(curB), .fluxCos(fCos), .fluxSin(fSin), .vfMode_q(vfMode),
        .secondFunc_q(second), .slipActive_q(slip), .tuningRequired_q(tune),
        .motorClass_q(mclass), .outFreq_q(outFreq), .outVolt_q(outVolt), .exciteCur_q(exc),
        .torqueCur_q(trq));
    dcms_term_ctrl u_ext (.core_clk(core_clk), .nrst(nrst), .swCmd(swCmd), .runCmd(runCmd),
        .lateOk(lateOk), .auxCmd(auxCmd), .termIn(termIn), .running(running));
    // Clock and timeout
    always #12.5 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One bus transfer, held until waitrequest is seen low
    task automatic busOp(input logic [7:0] a, input logic w, input logic [15:0] d,
        output logic [31:0] q);
        @(posedge core_clk);
        avsAddr <= a;
        avsRead <= !w;
        avsWrite <= w;
        avsWdata <= {16'h0000, d};
        @(posedge core_clk);
        while (avsWait !== 1'b0)
            @(posedge core_clk);
        q = avsRdata;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] q;
        busOp(a, 1'b1, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] ex);
        logic [31:0] q;
        busOp(a, 1'b0, 16'h0000, q);
        `CHK("readdata", {16'h0000, ex}, q)
    endtask
    task automatic settle();
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    task automatic ext(input logic sw, input logic run, input logic late);
        @(posedge core_clk);
        swCmd <= sw;
        runCmd <= run;
        lateOk <= late;
        settle();
    endtask
    task automatic chkOut(input logic v, input logic s, input logic sl);
        `CHK("vfMode", v, vfMode)
        `CHK("secondFunc", s, second)
        `CHK("slipActive", sl, slip)
    endtask
    // Main sequence
    initial
    begin
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        settle();
        chkOut(1, 0, 0);
        foreach (rAddr[i]) rd(rAddr[i], rVal[i]);
        wr(8'h3c, 16'h1234);
        rd(8'h3c, 16'h0000);
        wr(8'h38, 16'h00ff);
        rd(8'h38, 16'h0001);
        foreach (mCode[i])
        begin
            wr(8'h04, mCode[i]);
            settle();
            `CHK("motorClass", mCls[i], mclass)
            `CHK("tuningReq", (mCode[i] == 3 || mCode[i] == 13), tune)
        end
        wr(8'h04, 16'h0002);
        rd(8'h04, 16'h0035);
        wr(8'h04, 16'h0003);
        wr(8'h34, 16'h0001);
        settle();
        `CHK("tuningReq", 1'b0, tune)
        wr(8'h04, 16'h0000);
        wr(8'h00, 16'h0009);
        wr(8'h00, 16'h05dd);
        rd(8'h00, 16'h270f);
        wr(8'h00, 16'h0096);
        freqCmd <= 16'h1770;
        auxCmd <= 4'hf;
        settle();
        chkOut(0, 0, 0);
        wr(8'h18, 16'h0012);
        ext(1, 0, 0);
        chkOut(1, 0, 0);
        ext(0, 0, 0);
        wr(8'h08, 16'h1388);
        wr(8'h08, 16'h1389);
        rd(8'h08, 16'h1388);
        settle();
        chkOut(0, 0, 1);
        @(posedge core_clk);
        freqCmd <= 16'h1771;
        settle();
        chkOut(0, 0, 1);
        wr(8'h10, 16'h0000);
        settle();
        chkOut(0, 0, 0);
        @(posedge core_clk);
        freqCmd <= 16'h1770;
        settle();
        chkOut(0, 0, 1);
        wr(8'h14, 16'h0001);
        wr(8'h08, 16'h0000);
        wr(8'h0c, 16'h0064);
        rd(8'h08, 16'h1388);
        rd(8'h0c, 16'h0032);
        wr(8'h14, 16'h0000);
        wr(8'h0c, 16'h03e8);
        wr(8'h0c, 16'h03e9);
        wr(8'h0c, 16'h0000);
        rd(8'h0c, 16'h03e8);
        wr(8'h08, 16'h0000);
        settle();
        chkOut(0, 0, 0);
        `CHK("outFreq", 16'h1770, outFreq)
        wr(8'h08, 16'h0001);
        settle();
        chkOut(0, 0, 1);
        ext(0, 1, 0);
        ext(1, 1, 1);
        chkOut(0, 1, 1);
        rd(8'h38, 16'h0016);
        ext(1, 0, 1);
        chkOut(1, 0, 0);
        ext(0, 0, 0);
        ext(0, 1, 0);
        wr(8'h00, 16'h270f);
        settle();
        chkOut(0, 1, 1);
        ext(0, 0, 0);
        chkOut(1, 0, 0);
        @(posedge core_clk);
        freqCmd <= 16'h0bb8;
        repeat (120) @(posedge core_clk);
        @(negedge core_clk);
        `CHK("outVolt", 16'h03e8, outVolt)
        @(posedge core_clk);
        curA <= 16'sh4000;
        curB <= 16'sh2000;
        fCos <= 16'sh4000;
        settle();
        `CHK("exciteCur", 16'sh2000, exc)
        `CHK("torqueCur", 16'sh1000, trq)
        tally_and_finish();
    end
endmodule // drive_control_mode_select_tb
`default_nettype wire
